// *** hw/sector_format_pkg.sv ***
`default_nettype none
package sector_format_pkg;
   typedef logic [16:0][7:0] coef_t;

   localparam int unsigned FRAME_BYTES = 2064;
   localparam int unsigned ROW_BYTES   = 172;
   localparam int unsigned BLK_COLS    = 182;
   localparam int unsigned DATA_ROWS   = 192;
   localparam int unsigned BLK_ROWS    = 208;
   localparam int unsigned PO_LEN      = 16;
   localparam int unsigned PI_LEN      = 10;
   localparam int unsigned IED_LEN     = 2;
   localparam int unsigned REC_ROWS    = 13;
   localparam int unsigned REC_FRAMES  = 16;
   localparam int unsigned MEM_DEPTH   = BLK_ROWS * BLK_COLS;

   localparam logic [11:0] POS_IED0    = 12'h004;
   localparam logic [11:0] POS_IED1    = 12'h005;
   localparam logic [11:0] POS_RES     = 12'h006;
   localparam logic [11:0] POS_DATA    = 12'h00C;
   localparam logic [11:0] POS_EDC     = 12'h80C;
   localparam logic [11:0] POS_LAST    = 12'h80F;
   localparam logic [7:0]  COL_LAST    = 8'hAB;
   localparam logic [7:0]  BCOL_LAST   = 8'hB5;
   localparam logic [7:0]  DROW_LAST   = 8'hBF;
   localparam logic [7:0]  BROW_LAST   = 8'hCF;
   localparam logic [7:0]  PO_ROW0     = 8'hC0;
   localparam logic [7:0]  PI_COL0     = 8'hAC;
   localparam logic [3:0]  FRAME_ROWS  = 4'hC;
   localparam logic [3:0]  LAST_FRAME  = 4'hF;

   localparam logic [7:0]  GF_POLY_LOW = 8'h1D;
   localparam logic [31:0] EDC_POLY    = 32'h8000_0011;
   localparam int unsigned SCR_TAP_HI  = 14;
   localparam int unsigned SCR_TAP_LO  = 10;
   localparam logic [15:0] SCR_PRESET [16] = '{
      16'h0001, 16'h5500, 16'h0002, 16'h2A00, 16'h0004, 16'h5400, 16'h8000, 16'h2800,
      16'h0010, 16'h5000, 16'h0020, 16'h2001, 16'h0040, 16'h4002, 16'h0800, 16'h0005};

   function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] t;
      p = 8'h00;
      t = a;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) p = p ^ t;
         t = t[7] ? ((t << 1) ^ GF_POLY_LOW) : (t << 1);
      end
      return p;
   endfunction

   function automatic coef_t rs_gen(input int unsigned n);
      coef_t      g;
      logic [7:0] a;
      g    = '0;
      g[0] = 8'h01;
      a    = 8'h01;
      for (int unsigned k = 0; k < n; k++) begin
         for (int i = 16; i > 0; i--) g[i] = g[i-1] ^ gf_mul(g[i], a);
         g[0] = gf_mul(g[0], a);
         a    = gf_mul(a, 8'h02);
      end
      return g;
   endfunction

   localparam coef_t G_PO  = rs_gen(PO_LEN);
   localparam coef_t G_PI  = rs_gen(PI_LEN);
   localparam coef_t G_IED = rs_gen(IED_LEN);

   function automatic logic [15:0] ied_calc(input logic [31:0] hdr);
      logic [7:0] p1;
      logic [7:0] p0;
      logic [7:0] fb;
      p1 = 8'h00;
      p0 = 8'h00;
      for (int i = 3; i >= 0; i--) begin
         fb = 8'(hdr >> (8 * i)) ^ p1;
         p1 = p0 ^ gf_mul(fb, G_IED[1]);
         p0 = gf_mul(fb, G_IED[0]);
      end
      return {p1, p0};
   endfunction

   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? EDC_POLY : 32'h0000_0000);
      end
      return r;
   endfunction

   function automatic logic [14:0] scr_shift8(input logic [14:0] s);
      logic [14:0] r;
      r = s;
      for (int i = 0; i < 8; i++) r = {r[13:0], r[SCR_TAP_HI] ^ r[SCR_TAP_LO]};
      return r;
   endfunction

   function automatic logic [15:0] blk_addr(input logic [7:0] row, input logic [7:0] col);
      return 16'(row) * 16'(BLK_COLS) + 16'(col);
   endfunction
endpackage
`default_nettype wire

// *** hw/block_ram.sv ***
`default_nettype none
module block_ram
   import sector_format_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        we_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   output var  logic [7:0]  rdata_o
);
   logic [7:0] mem [MEM_DEPTH];

   // Registered read, one cycle latency
   always_ff @(posedge clk_sys_i) begin
      if (we_i) mem[addr_i] <= wdata_i;
      rdata_o <= mem[addr_i];
   end
endmodule
`default_nettype wire

// *** hw/mod_encoder.sv ***
`default_nettype none
module mod_encoder
   import sector_format_pkg::*;
#(
   parameter logic [17:0] CODE_TABLE [1024] = '{default: 18'h00000},
   parameter bit          CHECK_RLL         = 1'b0
) (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   input  wire logic [7:0] byte_i,
   input  wire logic       byte_valid_i,
   output var  logic       byte_ready_o,
   output var  logic       channel_bit_o,
   output var  logic       channel_valid_o
);
   logic [15:0] sh;
   logic [4:0]  cnt;
   logic [1:0]  enc_state;
   logic        level;
   logic [15:0] next_sh;
   logic [4:0]  next_cnt;
   logic [1:0]  next_enc_state;
   logic        next_level;
   logic        next_bit;
   logic        next_valid;
   logic        load;
   logic [17:0] entry;

   always_comb begin
      byte_ready_o   = (cnt <= 5'd1);
      load           = byte_ready_o && byte_valid_i;
      entry          = CODE_TABLE[{enc_state, byte_i}];
      next_sh        = sh;
      next_cnt       = cnt;
      next_enc_state = enc_state;
      next_level     = level;
      next_bit       = channel_bit_o;
      next_valid     = 1'b0;
      if (cnt != 5'd0) begin
         next_level = level ^ sh[15];
         next_bit   = level ^ sh[15];
         next_valid = 1'b1;
         next_sh    = {sh[14:0], 1'b0};
         next_cnt   = cnt - 5'd1;
      end
      if (load) begin
         next_sh        = entry[15:0];
         next_cnt       = 5'd16;
         next_enc_state = entry[17:16];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sh              <= 16'h0000;
         cnt             <= 5'd0;
         enc_state       <= 2'd0;
         level           <= 1'b0;
         channel_bit_o   <= 1'b0;
         channel_valid_o <= 1'b0;
      end else begin
         sh              <= next_sh;
         cnt             <= next_cnt;
         enc_state       <= next_enc_state;
         level           <= next_level;
         channel_bit_o   <= next_bit;
         channel_valid_o <= next_valid;
      end
   end

   // Zero run since the last one, for the run length check
   logic [4:0] zrun;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) zrun <= 5'd2;
      else if (cnt != 5'd0) zrun <= sh[15] ? 5'd0 : ((zrun == 5'd31) ? zrun : zrun + 5'd1);
   end

   // Cycles since the last load, saturating, for the word length check
   logic [4:0] since_load;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) since_load <= 5'd31;
      else if (load) since_load <= 5'd0;
      else if (since_load != 5'd31) since_load <= since_load + 5'd1;
   end

   chk_word_length: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (since_load != 5'd0) && (since_load <= 5'd17) |-> (channel_valid_o == (since_load != 5'd17)))
      else $error("code word not sixteen bits");
   chk_nrzi_level: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (cnt != 5'd0) |=> channel_bit_o == ($past(level) ^ $past(sh[15])))
      else $error("channel level does not follow code bit");
   chk_run_length: assert property (@(posedge clk_sys_i) disable iff (rst_i || !CHECK_RLL)
      (cnt != 5'd0) |-> (sh[15] ? (zrun >= 5'd2) : (zrun < 5'd10))) else $error("run length out of range");
   cov_word_chain: cover property (@(posedge clk_sys_i) disable iff (rst_i) (cnt == 5'd1) && load);
endmodule
`default_nettype wire

// *** hw/sector_format_encoder.sv ***
// How it works
// - Header check: four header bytes mod two-root generator
// - Symbol math in GF(256), polynomial 0x11D
// - Reserved bytes from application, else zeros
// - Frame check spans first 2060 bytes, MSB first
// - Frame check is CRC remainder, bit 31 first
// - Fifteen-bit scrambler, low byte per eight shifts
// - Preset index is header bits 7 to 4
// - Frame start loads preset chosen by index
// - First byte from preset, then shift, XOR
// - Sixteen frames into 208 by 182 array
// - Outer parity: sixteen bytes per column
// - Inner parity: ten bytes per row, all rows
// - Outer parity rows interleaved after every twelve
// - Sixteen recording frames of 13 by 182
// - Byte and state map to code word, state
// - Code stream zero runs come from CODE_TABLE, two-to-ten check off (CHECK_RLL)
// - NRZI: each one toggles the channel level
// - Frame of 2064 bytes, header, checks, data
// - Header low 24 bits carry sector number
`default_nettype none
module sector_format_encoder
   import sector_format_pkg::*;
#(
   parameter logic [17:0] CODE_TABLE [1024] = '{default: 18'h00000}
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire logic [23:0] sector_number_i,
   input  wire logic [7:0]  sector_info_i,
   input  wire logic [47:0] reserved_i,
   input  wire logic        reserved_en_i,
   input  wire logic [7:0]  data_i,
   input  wire logic        data_valid_i,
   output var  logic        data_ready_o,
   output var  logic        channel_bit_o,
   output var  logic        channel_valid_o
);
   typedef enum logic [7:0] {
      S_FILL = 8'b0000_0001,
      S_POC  = 8'b0000_0010,
      S_POW  = 8'b0000_0100,
      S_PIC  = 8'b0000_1000,
      S_PIW  = 8'b0001_0000,
      S_ORD  = 8'b0010_0000,
      S_OWT  = 8'b0100_0000,
      S_OHD  = 8'b1000_0000
   } state_t;

   state_t      state;
   state_t      next_state;
   logic [11:0] pos;
   logic [11:0] next_pos;
   logic [7:0]  oa;
   logic [7:0]  next_oa;
   logic [7:0]  ib;
   logic [7:0]  next_ib;
   logic [3:0]  fr;
   logic [3:0]  next_fr;
   logic [3:0]  rr;
   logic [3:0]  next_rr;
   logic [31:0] hdr;
   logic [31:0] next_hdr;
   logic [47:0] res;
   logic [47:0] next_res;
   logic        res_en;
   logic        next_res_en;
   logic [14:0] scr;
   logic [14:0] next_scr;
   logic [31:0] crc;
   logic [31:0] next_crc;
   coef_t       par;
   coef_t       next_par;
   logic        pend;
   logic        next_pend;
   logic [7:0]  obyte;
   logic [7:0]  next_obyte;
   logic        ovalid;
   logic        next_ovalid;
   logic        next_ready;

   logic        mem_we;
   logic [15:0] mem_addr;
   logic [7:0]  mem_wdata;
   logic [7:0]  mem_rdata;
   logic        mod_ready;
   logic [31:0] cur_hdr;
   logic [47:0] cur_res;
   logic        cur_res_en;
   logic [15:0] header_check_bytes;
   logic [7:0]  fbyte;
   logic        is_data;
   logic        step;
   logic [4:0]  plen;
   coef_t       coef;
   logic [7:0]  fb;
   logic [7:0]  src_row;

   block_ram u_ram (
      .clk_sys_i (clk_sys_i),
      .we_i      (mem_we),
      .addr_i    (mem_addr),
      .wdata_i   (mem_wdata),
      .rdata_o   (mem_rdata)
   );

   mod_encoder #(
      .CODE_TABLE (CODE_TABLE),
      .CHECK_RLL  (1'b0)
   ) u_mod (
      .clk_sys_i       (clk_sys_i),
      .rst_i           (rst_i),
      .byte_i          (obyte),
      .byte_valid_i    (ovalid),
      .byte_ready_o    (mod_ready),
      .channel_bit_o   (channel_bit_o),
      .channel_valid_o (channel_valid_o)
   );

   // Frame byte assembly
   always_comb begin
      cur_hdr    = (pos == 12'h000) ? {sector_info_i, sector_number_i} : hdr;
      cur_res    = (pos == 12'h000) ? reserved_i : res;
      cur_res_en = (pos == 12'h000) ? reserved_en_i : res_en;
      header_check_bytes        = ied_calc(cur_hdr);
      is_data    = (pos >= POS_DATA) && (pos < POS_EDC);
      if (pos < POS_IED0) begin
         fbyte = 8'(cur_hdr >> {~pos[1:0], 3'b000});
      end else if (pos == POS_IED0) begin
         fbyte = header_check_bytes[15:8];
      end else if (pos == POS_IED1) begin
         fbyte = header_check_bytes[7:0];
      end else if (pos < POS_DATA) begin
         fbyte = cur_res_en ? 8'(cur_res >> {3'(3'd5 - 3'(pos - POS_RES)), 3'b000}) : 8'h00;
      end else if (is_data) begin
         fbyte = data_i ^ scr[7:0];
      end else begin
         fbyte = 8'(crc >> {2'(2'd3 - 2'(pos - POS_EDC)), 3'b000});
      end
   end

   always_comb begin
      next_state  = state;
      next_pos    = pos;
      next_oa     = oa;
      next_ib     = ib;
      next_fr     = fr;
      next_rr     = rr;
      next_hdr    = hdr;
      next_res    = res;
      next_res_en = res_en;
      next_scr    = scr;
      next_crc    = crc;
      next_par    = par;
      next_pend   = 1'b0;
      next_obyte  = obyte;
      next_ovalid = ovalid;
      mem_we      = 1'b0;
      mem_addr    = blk_addr(oa, ib);
      mem_wdata   = 8'h00;
      step        = 1'b0;
      plen        = (state == S_POC || state == S_POW) ? 5'(PO_LEN) : 5'(PI_LEN);
      coef        = (state == S_POC) ? G_PO : G_PI;
      fb          = mem_rdata ^ par[plen - 5'd1];
      src_row     = (rr == FRAME_ROWS) ? PO_ROW0 + 8'(fr) : 8'(fr) * 8'(FRAME_ROWS) + 8'(rr);
      // Parity feed from the read issued one cycle earlier
      if (pend) begin
         for (int k = 0; k < 16; k++) begin
            next_par[k] = (k < 32'(plen)) ? (((k > 0) ? par[k-1] : 8'h00) ^ gf_mul(fb, coef[k])) : 8'h00;
         end
      end
      case (state)
         S_FILL: begin
            step = is_data ? (data_ready_o && data_valid_i) : 1'b1;
            if (step) begin
               mem_we    = 1'b1;
               mem_wdata = fbyte;
               if (pos == 12'h000) begin
                  next_hdr    = cur_hdr;
                  next_res    = cur_res;
                  next_res_en = cur_res_en;
                  next_scr    = SCR_PRESET[sector_number_i[7:4]][14:0];
               end
               if (is_data) next_scr = scr_shift8(scr);
               if (pos < POS_EDC) next_crc = crc_byte((pos == 12'h000) ? 32'h0000_0000 : crc, fbyte);
               next_pos = (pos == POS_LAST) ? 12'h000 : pos + 12'h001;
               next_ib  = (ib == COL_LAST) ? 8'h00 : ib + 8'h01;
               if (ib == COL_LAST) next_oa = oa + 8'h01;
               if (ib == COL_LAST && oa == DROW_LAST) begin
                  next_state = S_POC;
                  next_oa    = 8'h00;
               end
            end
         end
         S_POC: begin
            mem_addr  = blk_addr(ib, oa);
            next_pend = (ib < 8'(DATA_ROWS));
            if (ib < 8'(DATA_ROWS)) next_ib = ib + 8'h01;
            if (ib == 8'(DATA_ROWS) && pend) begin
               next_state = S_POW;
               next_ib    = 8'h00;
            end
         end
         S_PIC: begin
            mem_addr  = blk_addr(oa, ib);
            next_pend = (ib < 8'(ROW_BYTES));
            if (ib < 8'(ROW_BYTES)) next_ib = ib + 8'h01;
            if (ib == 8'(ROW_BYTES) && pend) begin
               next_state = S_PIW;
               next_ib    = 8'h00;
            end
         end
         S_POW, S_PIW: begin
            mem_we    = 1'b1;
            mem_addr  = (state == S_POW) ? blk_addr(PO_ROW0 + ib, oa) : blk_addr(oa, PI_COL0 + ib);
            mem_wdata = par[plen - 5'd1];
            for (int k = 0; k < 16; k++) begin
               next_par[k] = (k > 0 && k < 32'(plen)) ? par[k-1] : 8'h00;
            end
            next_ib = ib + 8'h01;
            if (ib == 8'(plen - 5'd1)) begin
               next_ib    = 8'h00;
               next_oa    = oa + 8'h01;
               next_state = (state == S_POW) ? S_POC : S_PIC;
               if (state == S_POW && oa == COL_LAST) begin
                  next_state = S_PIC;
                  next_oa    = 8'h00;
               end
               if (state == S_PIW && oa == BROW_LAST) begin
                  next_state = S_ORD;
                  next_oa    = 8'h00;
                  next_fr    = 4'h0;
                  next_rr    = 4'h0;
               end
            end
         end
         S_ORD: begin
            mem_addr   = blk_addr(src_row, ib);
            next_state = S_OWT;
         end
         S_OWT: begin
            next_obyte  = mem_rdata;
            next_ovalid = 1'b1;
            next_state  = S_OHD;
         end
         S_OHD: begin
            if (mod_ready) begin
               next_ovalid = 1'b0;
               next_state  = S_ORD;
               next_ib     = (ib == BCOL_LAST) ? 8'h00 : ib + 8'h01;
               if (ib == BCOL_LAST) begin
                  next_rr = (rr == FRAME_ROWS) ? 4'h0 : rr + 4'h1;
                  if (rr == FRAME_ROWS) next_fr = fr + 4'h1;
                  if (rr == FRAME_ROWS && fr == LAST_FRAME) begin
                     next_state = S_FILL;
                     next_pos   = 12'h000;
                  end
               end
            end
         end
         default: begin
            next_state = S_FILL;
         end
      endcase
      next_ready = (next_state == S_FILL) && (next_pos >= POS_DATA) && (next_pos < POS_EDC);
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state        <= S_FILL;
         pos          <= 12'h000;
         oa           <= 8'h00;
         ib           <= 8'h00;
         fr           <= 4'h0;
         rr           <= 4'h0;
         hdr          <= 32'h0000_0000;
         res          <= 48'h0000_0000_0000;
         res_en       <= 1'b0;
         scr          <= 15'h0000;
         crc          <= 32'h0000_0000;
         par          <= '0;
         pend         <= 1'b0;
         obyte        <= 8'h00;
         ovalid       <= 1'b0;
         data_ready_o <= 1'b0;
      end else begin
         state        <= next_state;
         pos          <= next_pos;
         oa           <= next_oa;
         ib           <= next_ib;
         fr           <= next_fr;
         rr           <= next_rr;
         hdr          <= next_hdr;
         res          <= next_res;
         res_en       <= next_res_en;
         scr          <= next_scr;
         crc          <= next_crc;
         par          <= next_par;
         pend         <= next_pend;
         obyte        <= next_obyte;
         ovalid       <= next_ovalid;
         data_ready_o <= next_ready;
      end
   end

   // Length of the current parity write run, for the parity count checks
   logic [4:0] wr_run;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) wr_run <= 5'd0;
      else if (state == S_POW || state == S_PIW) wr_run <= wr_run + 5'd1;
      else wr_run <= 5'd0;
   end

   chk_ready_data_only: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      data_ready_o |-> (state == S_FILL) && (pos >= POS_DATA) && (pos < POS_EDC))
      else $error("input ready outside main data");
   chk_scr_preset: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state == S_FILL) && (pos == 12'h000) |=> scr == SCR_PRESET[$past(sector_number_i[7:4])][14:0])
      else $error("scrambler not preset at frame start");
   chk_scr_advance: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state == S_FILL) && is_data && step |=> scr == scr_shift8($past(scr)))
      else $error("scrambler did not advance by one byte");
   chk_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state == S_FILL) && (pos >= POS_RES) && (pos < POS_DATA) && !res_en |-> mem_wdata == 8'h00)
      else $error("reserved byte not zero");
   chk_edc_first: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state == S_FILL) && (pos == POS_EDC) |-> mem_wdata == crc[31:24])
      else $error("frame check not most significant byte first");
   chk_row_map: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state == S_ORD) |-> ((rr == FRAME_ROWS) ?
         (9'(src_row) == 9'd191 + (9'(fr) * 9'd13 + 9'(rr) + 9'd1) / 9'd13) :
         (9'(src_row) + 9'(src_row / 8'd12) == 9'(fr) * 9'd13 + 9'(rr))))
      else $error("recording row mapping wrong");
   chk_po_rows: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state == S_POC) && (ib == 8'(DATA_ROWS)) && pend |=>
         ((state == S_POW) && (wr_run == 5'd0)) ##16 ((state != S_POW) && (wr_run == 5'd16)))
      else $error("outer parity not sixteen rows");
   chk_pi_cols: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state == S_PIC) && (ib == 8'(ROW_BYTES)) && pend |=>
         ((state == S_PIW) && (wr_run == 5'd0)) ##10 ((state != S_PIW) && (wr_run == 5'd10)))
      else $error("inner parity not ten columns");
   cov_block_done: cover property (@(posedge clk_sys_i) disable iff (rst_i) (state == S_PIW) ##1 (state == S_ORD));
   cov_frame_end: cover property (@(posedge clk_sys_i) disable iff (rst_i) (state == S_FILL) && (pos == POS_LAST));
   cov_input_stall: cover property (@(posedge clk_sys_i) disable iff (rst_i) data_ready_o && !data_valid_i);
endmodule
`default_nettype wire

// *** test/channel_receiver.sv ***
`default_nettype none
module channel_receiver (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire logic        channel_bit_i,
   input  wire logic        channel_valid_i,
   output var  logic [15:0] word_o,
   output var  logic        word_valid_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       last;
   logic [3:0] cnt;
   // NRZI decode, sixteen bits per word, first bit is msb
   always_ff @(posedge clk_sys_i) begin
      word_valid_o <= 1'b0;
      if (rst_i) begin
         last <= 1'b0;
         cnt  <= 4'h0;
      end else if (channel_valid_i) begin
         word_o       <= {word_o[14:0], channel_bit_i ^ last};
         last         <= channel_bit_i;
         cnt          <= cnt + 4'h1;
         word_valid_o <= (cnt == 4'hF);
      end
   end
endmodule
`default_nettype wire

// *** test/sector_format_encoder_tb.sv ***
`default_nettype none
module sector_format_encoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sector_format_pkg::*;
   typedef logic [17:0] tbl_t [1024];
   function automatic tbl_t mk_tbl();
      tbl_t t;
      for (int i = 0; i < 1024; i++) t[i] = {i[1:0], i[7:0], ~i[7:0] ^ {6'h00, i[9:8]}};
      return t;
   endfunction
   localparam tbl_t TBL = mk_tbl();
   logic        clk_sys_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [23:0] sector_number_i = 24'h000000;
   logic [7:0]  sector_info_i = 8'h00;
   logic [47:0] reserved_i = 48'h0;
   logic        reserved_en_i = 1'b0;
   logic [7:0]  data_i = 8'h00;
   logic        data_valid_i = 1'b0;
   logic        data_ready_o;
   logic        channel_bit_o;
   logic        channel_valid_o;
   logic        word_valid;
   logic [15:0] word;
   logic [14:0] scr_s;
   logic [7:0]  exp_q [$];
   int          bad_count = 0;
   int          n_checks = 0;
   int          seed = 32'hb0ff;
   always #10 clk_sys_i = ~clk_sys_i;
   sector_format_encoder #(.CODE_TABLE(TBL)) i_sector_format_encoder (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .sector_number_i(sector_number_i), .sector_info_i(sector_info_i), .reserved_i(reserved_i),
      .reserved_en_i(reserved_en_i), .data_i(data_i), .data_valid_i(data_valid_i), .data_ready_o(data_ready_o),
      .channel_bit_o(channel_bit_o), .channel_valid_o(channel_valid_o));
   channel_receiver i_channel_receiver (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .channel_bit_i(channel_bit_o),
      .channel_valid_i(channel_valid_o), .word_o(word), .word_valid_o(word_valid));
   function automatic logic [7:0] mul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      p = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) p ^= a;
         a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1D : 8'h00);
      end
      return p;
   endfunction
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Counts low cycles of ready, bounded
   task automatic gap(input int exp);
      int n;
      n = 0;
      @(negedge clk_sys_i);
      while (data_ready_o !== 1'b1 && n < 400) begin
         n++;
         @(negedge clk_sys_i);
      end
      chk("ready gap", 16'(exp), 16'(n));
   endtask
   // One frame of 2048 bytes with random stalls
   task automatic feed(input int f);
      int k;
      k = 0;
      while (k < 2048) begin
         @(posedge clk_sys_i);
         #1;
         data_valid_i = ($random(seed) & 15) != 0;
         data_i = 8'($random(seed));
         @(negedge clk_sys_i);
         if (data_ready_o !== 1'b1) begin
            chk("ready held", 16'h0001, 16'(data_ready_o));
            return;
         end
         if (data_valid_i) begin
            if (f == 0 && k < 160) exp_q.push_back(data_i ^ scr_s[7:0]);
            for (int b = 0; b < 8; b++) scr_s = {scr_s[13:0], scr_s[14] ^ scr_s[10]};
            k++;
         end
      end
      @(posedge clk_sys_i);
      #1;
      data_valid_i = 1'b0;
      sector_number_i = sector_number_i + 24'h000001;
      reserved_en_i = ~reserved_en_i;
   endtask
   initial begin
      logic [31:0] hdr;
      logic [7:0]  g [11];
      logic [7:0]  r [10];
      logic [7:0]  a;
      logic [7:0]  p1;
      logic [7:0]  p0;
      logic [7:0]  fb;
      logic [1:0]  st;
      int          n;
      sector_number_i = 24'($random(seed)) & 24'hFFFFF0;
      sector_info_i = 8'($random(seed));
      reserved_i = {32'($random(seed)), 16'($random(seed))};
      reserved_en_i = 1'($random(seed));
      hdr = {sector_info_i, sector_number_i};
      p1 = 8'h00;
      p0 = 8'h00;
      for (int i = 3; i >= 0; i--) begin
         exp_q.push_back(hdr[8*i +: 8]);
         fb = hdr[8*i +: 8] ^ p1;
         p1 = p0 ^ mul(fb, 8'h03);
         p0 = mul(fb, 8'h02);
      end
      exp_q.push_back(p1);
      exp_q.push_back(p0);
      for (int i = 5; i >= 0; i--) exp_q.push_back(reserved_en_i ? reserved_i[8*i +: 8] : 8'h00);
      scr_s = SCR_PRESET[sector_number_i[7:4]][14:0];
      repeat (12) @(posedge clk_sys_i);
      #1;
      rst_i = 1'b0;
      gap(12);
      for (int f = 0; f < 16; f++) begin
         feed(f);
         gap(f == 15 ? 400 : 16);
         $display("frame %0d done", f);
      end
      g[0] = 8'h01;
      for (int i = 1; i < 11; i++) g[i] = 8'h00;
      a = 8'h01;
      for (int k = 0; k < 10; k++) begin
         for (int i = 10; i > 0; i--) g[i] = g[i-1] ^ mul(g[i], a);
         g[0] = mul(g[0], a);
         a = mul(a, 8'h02);
      end
      for (int i = 0; i < 10; i++) r[i] = 8'h00;
      for (int j = 0; j < 172; j++) begin
         fb = exp_q[j] ^ r[9];
         for (int i = 9; i > 0; i--) r[i] = r[i-1] ^ mul(fb, g[i]);
         r[0] = mul(fb, g[0]);
      end
      for (int i = 9; i >= 0; i--) exp_q.push_back(r[i]);
      st = 2'h0;
      n = 0;
      for (int k = 0; k < 182; k++) begin
         while (word_valid !== 1'b1 && n < 90000) begin
            @(negedge clk_sys_i);
            n++;
         end
         if (n >= 90000) begin
            chk("output wait", 16'h0000, 16'hFFFF);
            break;
         end
         chk("byte", {8'h00, exp_q[k]}, {8'h00, word[15:8]});
         chk("code", {8'h00, ~exp_q[k] ^ {6'h00, st}}, {8'h00, word[7:0]});
         st = exp_q[k][1:0];
         @(negedge clk_sys_i);
      end
      $display("output test done");
      final_report();
   end
endmodule
`default_nettype wire
